//--- core/sacs_top.v
// Control, serial interface and conversion sequencer of the converter.
//
// Contract
// - Select high: output floating, inputs ignored.
// - Select seen after two rises, one fall.
// - Recognised low select presents result MSB.
// - Five address bits, MSB first, on rises.
// - First five falls shift bits two-six.
// - Sampling of new channel after fifth fall.
// - Sixth and seventh falls shift bits seven-eight.
// - Eighth fall holds; convert over 36 cycles.
// - Select may stay low across conversions.
// - Recognised select fall aborts running conversion.
// - New full access aborts; old result returned.
// - Shared clock: first two clocks recognise select.
// - Shared clock, select high: clock converts.
// - Strobed start: eighth fall starts hold, conversion.
// - Both clocks independent of each other.
// - Address 10011 selects internal self-test voltage.
`include "sacs_defines.vh"

module sacs_top (
   // Clock and reset.
   input  wire       mclk,
   input  wire       resetn,
   // Serial control pins from the host.
   input  wire       select_n,
   input  wire       addr_in,
   input  wire       transfer_clock,
   input  wire       system_clock,
   // Strap: one clock pin serves as both transfer and system clock.
   input  wire       shared_clock_mode,
   // Serial data output, three-state as level and enable.
   output reg        data_out,
   output reg        data_oe,
   // Analog front end control.
   output reg  [4:0] mux_channel,
   output reg        self_test_channel,
   output reg        sample_en,
   output reg        hold_en,
   output reg  [7:0] dac_code,
   input  wire       cmp_above,
   // Status.
   output reg        conv_busy,
   output reg  [7:0] result
);

   // Synchronised pins.
   wire       cs_lvl;
   wire       io_rise;
   wire       io_fall;
   wire       sys_rise;
   wire       sys_fall;
   wire       addr_lvl;
   wire       cmp_lvl;
   wire       mode_lvl;

   // Select recognition.
   reg        cs_low;
   reg  [1:0] cs_stage;
   reg        rec_low;

   // Frame state.
   reg  [3:0] rise_cnt;
   reg  [3:0] fall_cnt;
   reg  [4:0] addr_shift;
   reg  [7:0] out_shift;

   // Conversion state.
   reg  [5:0] conv_cnt;
   reg  [7:0] sar;

   wire       clk_rise;
   wire       clk_fall;
   wire       conv_tick;
   wire       io_ok_rise;
   wire       io_ok_fall;
   wire [3:0] step;
   wire       decide;
   wire [7:0] sar_dec;

   // Trial bit of a successive approximation step.
   function [7:0] bit_mask;
      input [3:0] k;
      begin
         bit_mask = 8'h80 >> k[2:0];
      end
   endfunction

   // Every pin is foreign to mclk and is synchronised first.
   // Each pin reaches the logic three mclk cycles after it moves, so a
   // pulse on a clock pin shorter than one mclk period may be lost.
   // Select and the clock pins share that delay, so their order holds.
   sacs_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (
      .mclk   (mclk),
      .resetn (resetn),
      .pin    (select_n),
      .level  (cs_lvl),
      .rise   (),
      .fall   ()
   );

   sacs_sync u_sync_io (
      .mclk   (mclk),
      .resetn (resetn),
      .pin    (transfer_clock),
      .level  (),
      .rise   (io_rise),
      .fall   (io_fall)
   );

   sacs_sync u_sync_sys (
      .mclk   (mclk),
      .resetn (resetn),
      .pin    (system_clock),
      .level  (),
      .rise   (sys_rise),
      .fall   (sys_fall)
   );

   sacs_sync u_sync_addr (
      .mclk   (mclk),
      .resetn (resetn),
      .pin    (addr_in),
      .level  (addr_lvl),
      .rise   (),
      .fall   ()
   );

   sacs_sync u_sync_cmp (
      .mclk   (mclk),
      .resetn (resetn),
      .pin    (cmp_above),
      .level  (cmp_lvl),
      .rise   (),
      .fall   ()
   );

   sacs_sync u_sync_mode (
      .mclk   (mclk),
      .resetn (resetn),
      .pin    (shared_clock_mode),
      .level  (mode_lvl),
      .rise   (),
      .fall   ()
   );

   // In shared mode the transfer clock pin is also the system clock.
   // The system clock pin is then ignored; the strap must stay fixed
   // while the block runs, as a change in mid-frame breaks the count.
   assign clk_rise = mode_lvl ? io_rise : sys_rise;
   assign clk_fall = mode_lvl ? io_fall : sys_fall;

   // Shared mode converts only while select is recognised high.
   // A conversion started in shared mode therefore waits, frozen, until
   // the host raises select and the device recognises it.
   assign conv_tick = mode_lvl ? (io_rise & ~cs_low) : sys_rise;

   // Transfer edges count only once a low select is recognised, and not
   // in the very cycle of recognition, so the clocks that recognise select
   // in shared mode never shift an address bit.
   assign io_ok_rise = cs_low & ~rec_low & io_rise;
   assign io_ok_fall = cs_low & ~rec_low & io_fall;

   // Four system clocks per result bit; the last slot of each decides.
   // The comparator is synchronised, so the first three slots give the
   // trial code time to settle and cross into mclk. Eight bits take 32
   // clocks and the remaining four pad the conversion to its full length.
   assign step    = conv_cnt[5:2];
   assign decide  = (conv_cnt[1:0] == `SACS_BIT_SLOT_LAST) &&
                    (step < `SACS_BIT_STEPS);
   assign sar_dec = cmp_lvl ? (sar | bit_mask(step)) : sar;

   // A select change counts only after two rises and then a fall of the
   // system clock; bouncing back restarts the wait.
   // This wait is the only filter against a noisy select; a glitch
   // shorter than one system clock period is never recognised.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cs_low   <= 1'b0;
         cs_stage <= 2'h0;
         rec_low  <= 1'b0;
      end else begin
         rec_low <= 1'b0;
         if (cs_lvl != cs_low) begin
            cs_stage <= 2'h0;
         end else if (cs_stage < `SACS_CS_RISES) begin
            if (clk_rise) begin
               cs_stage <= cs_stage + 2'h1;
            end
         end else if (clk_fall) begin
            cs_stage <= 2'h0;
            cs_low   <= ~cs_lvl;
            rec_low  <= ~cs_lvl;
         end
      end
   end

   // Frame, output shifter and conversion share one process so that the
   // priority between abort, restart and completion is explicit.
   // Limitation: a frame cut short by raising select leaves its counters
   // and sampling as they stand until the next recognised fall of select.
   // A system clock edge that meets an abort or restart is not counted,
   // which only touches the conversion that is being discarded.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         data_out          <= 1'b0;
         data_oe           <= 1'b0;
         mux_channel       <= `SACS_ADDR_RESET;
         self_test_channel <= 1'b0;
         sample_en         <= 1'b0;
         hold_en           <= 1'b0;
         dac_code          <= 8'h00;
         conv_busy         <= 1'b0;
         result            <= `SACS_RESULT_RESET;
         rise_cnt          <= 4'h0;
         fall_cnt          <= 4'h0;
         addr_shift        <= `SACS_ADDR_RESET;
         out_shift         <= `SACS_RESULT_RESET;
         conv_cnt          <= 6'h00;
         sar               <= 8'h00;
      end else begin
         data_oe <= cs_low;
         if (rec_low) begin
            // A recognised fall of select resets the sequencer.
            // The result register is left alone, so an aborted
            // conversion still returns the last completed word.
            conv_busy <= 1'b0;
            hold_en   <= 1'b0;
            sample_en <= 1'b0;
            rise_cnt  <= 4'h0;
            fall_cnt  <= 4'h0;
            out_shift <= result;
            data_out  <= result[7];
            data_oe   <= 1'b1;
         end else if (cs_low && io_ok_fall &&
                      fall_cnt == `SACS_HOLD_FALL - 4'h1) begin
            // Eighth fall: hold and restart conversion, even over a
            // running one; the old result stays.
            sample_en <= 1'b0;
            hold_en   <= 1'b1;
            conv_busy <= 1'b1;
            conv_cnt  <= 6'h00;
            sar       <= 8'h00;
            dac_code  <= bit_mask(4'h0);
            rise_cnt  <= 4'h0;
            fall_cnt  <= 4'h0;
            // Next frame with select held low starts on the last result.
            out_shift <= result;
            data_out  <= result[7];
         end else begin
            if (io_ok_rise && rise_cnt < `SACS_ADDR_EDGES) begin
               addr_shift <= {addr_shift[3:0], addr_lvl};
               rise_cnt   <= rise_cnt + 4'h1;
            end
            if (io_ok_fall) begin
               fall_cnt <= fall_cnt + 4'h1;
               if (fall_cnt < `SACS_LAST_SHIFT) begin
                  // Falls one to seven shift bits two to eight.
                  data_out  <= out_shift[6];
                  out_shift <= {out_shift[6:0], 1'b0};
               end
               if (fall_cnt == `SACS_SAMPLE_FALL - 4'h1) begin
                  // Sampling opens after the fifth fall and runs until the
                  // eighth, which a strobing host may delay at will.
                  mux_channel <= addr_shift;
                  self_test_channel <=
                     (addr_shift == `SACS_SELF_TEST_ADDR);
                  sample_en   <= 1'b1;
               end
            end
            if (conv_busy && conv_tick) begin
               conv_cnt <= conv_cnt + 6'h01;
               if (decide) begin
                  sar <= sar_dec;
                  if (step < `SACS_BIT_STEPS - 4'h1) begin
                     dac_code <= sar_dec | bit_mask(step + 4'h1);
                  end else begin
                     dac_code <= sar_dec;
                  end
               end
               if (conv_cnt == `SACS_CONV_CYCLES - 6'h01) begin
                  // Conversion done after 36 system clocks.
                  result    <= sar;
                  conv_busy <= 1'b0;
                  hold_en   <= 1'b0;
                  // Idle frame under a held select shows the new MSB.
                  // A frame already under way keeps shifting the old
                  // result, so the host never sees a word torn in two.
                  if (cs_low && rise_cnt == 4'h0 && fall_cnt == 4'h0) begin
                     out_shift <= sar;
                     data_out  <= sar[7];
                  end
               end
            end
         end
      end
   end

endmodule // sacs_top

//--- core/sacs_defines.vh
// Shared constants of the serial converter control sequencer.
`ifndef SACS_DEFINES_VH
`define SACS_DEFINES_VH

// Field widths.
`define SACS_ADDR_BITS      5
`define SACS_RESULT_BITS    8
`define SACS_FALL_CNT_BITS  4
`define SACS_CONV_CNT_BITS  6

// Select recognition: rising system clock edges before the final fall.
`define SACS_CS_RISES       2'h2

// Transfer clock frame positions, counted in edges.
`define SACS_ADDR_EDGES     4'h5
`define SACS_SAMPLE_FALL    4'h5
`define SACS_HOLD_FALL      4'h8
`define SACS_LAST_SHIFT     4'h7

// Conversion timing in system clock cycles.
`define SACS_CONV_CYCLES    6'h24
`define SACS_BIT_SLOT_LAST  2'h3
`define SACS_BIT_STEPS      4'h8

// Self-test channel address and reset values.
`define SACS_SELF_TEST_ADDR 5'h13
`define SACS_RESULT_RESET   8'h00
`define SACS_ADDR_RESET     5'h00

`endif

//--- core/sacs_sync.v
// Two-flop synchroniser with a registered level and edge pulses.
module sacs_sync #(
   parameter RESET_LEVEL = 1'b0
) (
   // Clock and reset.
   input  wire mclk,
   input  wire resetn,
   // Asynchronous pin.
   input  wire pin,
   // Synchronised level and one-cycle edge pulses.
   output reg  level,
   output reg  rise,
   output reg  fall
);

   reg meta;
   reg stage2;

   // The first flop feeds only the second; edges are taken after stage2.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta   <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         level  <= RESET_LEVEL;
         rise   <= 1'b0;
         fall   <= 1'b0;
      end else begin
         meta   <= pin;
         stage2 <= meta;
         level  <= stage2;
         rise   <= stage2 & ~level;
         fall   <= ~stage2 & level;
      end
   end

endmodule // sacs_sync

//--- test/sacs_checker.sv
// Port checks for the converter control sequencer.
module sacs_checker (
   // Clock and reset.
   input wire       mclk,
   input wire       resetn,
   // Pins and strap.
   input wire       select_n,
   input wire       system_clock,
   input wire       shared_clock_mode,
   // Outputs under watch.
   input wire       data_out,
   input wire       data_oe,
   input wire [4:0] mux_channel,
   input wire       self_test_channel,
   input wire       sample_en,
   input wire       hold_en,
   input wire [7:0] dac_code,
   input wire       conv_busy,
   input wire [7:0] result
);
   timeunit 1ns;
   timeprecision 100ps;
   // System clock rises since hold began, lagged to match the pin sync.
   logic [2:0] sys_d;
   logic [7:0] cnt;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sys_d <= 3'h0;
         cnt   <= 8'h00;
      end else begin
         sys_d <= {sys_d[1:0], system_clock};
         if ($fell(sample_en))
            cnt <= 8'h00;
         else if (sys_d[1] && !sys_d[2] && cnt != 8'hff)
            cnt <= cnt + 8'h01;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   msb_first_a:
      assert property ($rose(data_oe) |-> data_out == result[7])
      else $error("MSB missing at enable");
   sel_low_wait_a:
      assert property ($rose(data_oe) |-> $past(select_n, 8) == 1'b0)
      else $error("select low taken too early");
   sel_high_wait_a:
      assert property ($fell(data_oe) |-> $past(select_n, 8))
      else $error("select high taken too early");
   self_test_a:
      assert property ($changed(mux_channel) |-> ##1
         (self_test_channel == (mux_channel == 5'h13)))
      else $error("self-test flag wrong");
   hold_start_a:
      assert property ($fell(sample_en) |->
         hold_en && conv_busy && dac_code == 8'h80)
      else $error("hold did not start");
   busy_hold_a:
      assert property (hold_en == conv_busy)
      else $error("hold and busy differ");
   sample_sel_a:
      assert property (sample_en |-> data_oe)
      else $error("sampling while deselected");
   conv_len_a:
      assert property ($fell(conv_busy) && !shared_clock_mode |-> cnt <= 8'h25)
      else $error("conversion too long");
   result_late_a:
      assert property ($changed(result) && !shared_clock_mode |-> cnt >= 8'h23)
      else $error("result loaded too early");
   addr_idle_a:
      assert property (select_n && !data_oe |=> $stable(mux_channel))
      else $error("channel moved while idle");
   cover property ($fell(sample_en));
   cover property ($rose(self_test_channel));
   cover property ($fell(conv_busy) && data_oe);
endmodule // sacs_checker

//--- test/sacs_host.sv
// Host model driving select, address and both clock pins.
module sacs_host (
   // Bench clock, places select changes.
   input  wire  mclk,
   // Serial result.
   input  wire  data_out,
   input  wire  data_oe,
   // Control pins.
   output logic select_n,
   output logic addr_in,
   output logic transfer_clock,
   output logic system_clock
);
   timeunit 1ns;
   timeprecision 100ps;
   // Free-running system clock, phase unrelated to mclk.
   initial begin
      system_clock = 1'b0;
      #3;
      forever #30 system_clock = ~system_clock;
   end
   initial begin
      select_n = 1'b1;
      addr_in = 1'b0;
      transfer_clock = 1'b0;
   end
   task automatic sel(input logic lvl);
      @(negedge mclk);
      select_n = lvl;
   endtask
   // Strobe stretches the high phase of the eighth cycle.
   task automatic frame(input logic [4:0] adr, input int strobe,
                        output logic [7:0] rd);
      sel(1'b0);
      for (int i = 0; i < 300 && data_oe !== 1'b1; i++) @(negedge mclk);
      for (int k = 0; k < 8; k++) begin
         addr_in = (k < 5) ? adr[4 - k] : ~addr_in;
         #40 transfer_clock = 1'b1;
         #(k == 7 ? 40 + strobe : 40);
         rd[7 - k] = data_out;
         transfer_clock = 1'b0;
      end
   endtask
   // Two recognition clocks, eight valid, then deselect.
   task automatic shared_frame(input logic [4:0] adr);
      sel(1'b0);
      for (int k = 0; k < 60; k++) begin
         if (k == 10) sel(1'b1);
         addr_in = (k > 1 && k < 7) ? adr[6 - k] : k[0];
         #40 transfer_clock = 1'b1;
         #40 transfer_clock = 1'b0;
      end
   endtask
   // Clock and address toggles while deselected must be ignored.
   task automatic noise();
      for (int k = 0; k < 8; k++) begin
         #40 transfer_clock = ~transfer_clock;
         addr_in = ~addr_in;
      end
   endtask
endmodule // sacs_host

//--- test/testbench.sv
// Self-checking bench for the converter control sequencer.
`include "sacs_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       mclk, resetn, shared_clock_mode;
   wire        select_n, addr_in, transfer_clock, system_clock, cmp_above;
   wire        data_out, data_oe, self_test_channel, sample_en;
   wire        hold_en, conv_busy;
   wire [4:0]  mux_channel;
   wire [7:0]  dac_code, result;
   logic [7:0] vin [32];
   logic [7:0] exp_q [$];
   logic [7:0] last, rd;
   int         n_errors, tests_run;
   assign cmp_above = vin[mux_channel] >= dac_code;
   sacs_top sacs_top_i (
      .mclk, .resetn, .select_n, .addr_in, .transfer_clock, .system_clock,
      .shared_clock_mode, .data_out, .data_oe, .mux_channel,
      .self_test_channel, .sample_en, .hold_en, .dac_code, .cmp_above,
      .conv_busy, .result
   );
   sacs_host sacs_host_i (
      .mclk, .data_out, .data_oe, .select_n, .addr_in, .transfer_clock,
      .system_clock
   );
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // A frame reads back the last completed result.
   task automatic access(input logic [4:0] ch, input int strobe);
      sacs_host_i.frame(ch, strobe, rd);
      check(rd, last);
      check({3'h0, mux_channel}, {3'h0, ch});
      exp_q.push_back(vin[ch]);
   endtask
   task automatic settle;
      for (int i = 0; i < 1000 && exp_q.size() > 0; i++) @(negedge mclk);
      check(8'(exp_q.size()), 8'h00);
   endtask
   always @(negedge conv_busy) begin
      @(negedge mclk);
      if (exp_q.size() > 0) begin
         check(result, exp_q[0]);
         last = exp_q.pop_front();
      end
   end
   initial begin
      logic [4:0] ch;
      void'($urandom(32'he80cbfec));
      foreach (vin[i]) vin[i] = 8'($urandom);
      vin[`SACS_SELF_TEST_ADDR] = 8'h80;
      last = 8'h00;
      resetn = 1'b0;
      shared_clock_mode = 1'b0;
      repeat (5) @(negedge mclk);
      resetn = 1'b1;
      for (int j = 0; j < 6; j++) begin
         ch = (j == 5) ? `SACS_SELF_TEST_ADDR : 5'($urandom % 19);
         access(ch, (j == 2) ? 500 : 0);
         sacs_host_i.sel(1'b1);
         settle();
         sacs_host_i.noise();
      end
      // Select held low; the second frame restarts the conversion.
      access(5'h01, 0);
      access(5'h02, 0);
      void'(exp_q.pop_front());
      settle();
      access(5'h03, 0);
      sacs_host_i.sel(1'b1);
      settle();
      // Reselecting during a conversion aborts it.
      access(5'h04, 0);
      sacs_host_i.sel(1'b1);
      for (int i = 0; i < 100 && data_oe !== 1'b0; i++) @(negedge mclk);
      void'(exp_q.pop_back());
      sacs_host_i.sel(1'b0);
      for (int i = 0; i < 100 && data_oe !== 1'b1; i++) @(negedge mclk);
      check({7'h0, conv_busy}, 8'h00);
      access(5'h05, 0);
      sacs_host_i.sel(1'b1);
      settle();
      shared_clock_mode = 1'b1;
      repeat (8) @(negedge mclk);
      exp_q.push_back(vin[6]);
      sacs_host_i.shared_frame(5'h06);
      check({3'h0, mux_channel}, 8'h06);
      settle();
      shared_clock_mode = 1'b0;
      repeat (8) @(negedge mclk);
      access(5'h07, 0);
      sacs_host_i.sel(1'b1);
      settle();
      // A reset in mid-run clears the result; the next frame reads zero.
      resetn = 1'b0;
      repeat (5) @(negedge mclk);
      check(result, `SACS_RESULT_RESET);
      check({7'h0, data_oe}, 8'h00);
      resetn = 1'b1;
      last = `SACS_RESULT_RESET;
      ch = 5'($urandom % 19);
      access(ch, 0);
      sacs_host_i.sel(1'b1);
      settle();
      print_verdict();
   end
   // About 14 frames of a few microseconds each; this leaves wide margin.
   initial begin
      #300us;
      n_errors++;
      print_verdict();
   end
endmodule // testbench
bind sacs_top sacs_checker sacs_checker_i (
   .mclk, .resetn, .select_n, .system_clock, .shared_clock_mode,
   .data_out, .data_oe, .mux_channel, .self_test_channel, .sample_en,
   .hold_en, .dac_code, .conv_busy, .result
);
